// ### inc/mgmt_pkg.sv
// Constants, register map and types of the module management block
package mgmt_pkg;
   localparam int          CLK_PERIOD_NS  = 25;
   localparam int          TX_OFF_MAX_US  = 10;
   // Longest time: round down
   localparam int          TX_OFF_CYC     = (TX_OFF_MAX_US * 1000) /
                                            CLK_PERIOD_NS;
   localparam logic [6:0]  ID_DEV_ADDR    = 7'h50;
   localparam logic [6:0]  DIAG_DEV_ADDR  = 7'h51;
   localparam int          MEM_DEPTH      = 256;
   localparam int          NUM_MON        = 5;
   localparam int          NUM_LIM        = 4;
   localparam int          MON_TEMP       = 0;
   localparam int          MON_BIAS       = 1;
   localparam int          MON_TXPWR      = 2;
   localparam int          MON_RXPWR      = 3;
   localparam int          MON_VCC        = 4;
   localparam int          LIM_HI_ALM     = 0;
   localparam int          LIM_LO_ALM     = 1;
   localparam int          LIM_HI_WRN     = 2;
   localparam int          LIM_LO_WRN     = 3;
   localparam logic [7:0]  DIAG_LIMIT_BASE = 8'h00;
   localparam logic [7:0]  DIAG_LIVE_BASE = 8'h60;
   localparam logic [7:0]  DIAG_LIVE_END  = 8'h6A;
   localparam logic [7:0]  DIAG_FLAG_BASE = 8'h70;
   localparam logic [7:0]  DIAG_RO_LO     = 8'h60;
   localparam logic [7:0]  DIAG_RO_HI     = 8'h72;
   localparam logic [11:0] REG_CTRL       = 12'h000;
   localparam logic [11:0] REG_STATUS     = 12'h004;
   localparam logic [11:0] REG_MASK       = 12'h008;
   localparam logic [11:0] REG_MEMADDR    = 12'h00C;
   localparam logic [11:0] REG_MEMDATA    = 12'h010;
   localparam logic [11:0] REG_STATE      = 12'h014;
   localparam int          CTRL_ID_WP     = 0;
   localparam int          CTRL_DIAG_WP   = 1;
   localparam logic [1:0]  CTRL_RESET     = 2'h1;
   localparam int          NUM_EV         = 5;
   localparam int          EV_ALARM       = 0;
   localparam int          EV_WARN        = 1;
   localparam int          EV_LOS         = 2;
   localparam int          EV_FAULT       = 3;
   localparam int          EV_HOST_WR     = 4;
   localparam int          MEMADDR_SEL    = 8;
   localparam logic [2:0]  PIN_IDLE       = 3'h7;
   localparam logic        LINE_IDLE      = 1'b1;
   typedef enum logic [2:0] {
      S_IDLE, S_RECV, S_ACK, S_SEND, S_MACK, S_IGNORE
   } tw_state_t;
   typedef enum logic [1:0] {PH_DEV, PH_WADDR, PH_DATA} tw_phase_t;
endpackage

// ### inc/diag_if.sv
// Monitored values, limits and flags between controller and comparator
`timescale 1ns/1ps
interface diag_if;
   logic [mgmt_pkg::NUM_MON-1:0][15:0]                       value;
   logic [mgmt_pkg::NUM_MON-1:0][mgmt_pkg::NUM_LIM-1:0][15:0] limit;
   logic [mgmt_pkg::NUM_MON-1:0][mgmt_pkg::NUM_LIM-1:0]       flag;
   logic                                                     tx_fault;
   modport mon (input value, input limit, output flag, output tx_fault);
   modport ctl (output value, output limit, input flag, input tx_fault);
endinterface

// ### logic/pin_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sync_state_t;

   sync_state_t r;
   sync_state_t next_r;

   always_comb begin
      next_r.meta = pin;
      next_r.sync = r.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= {RST_VAL, RST_VAL};
      end else begin
         r <= next_r;
      end
   end

   assign sync = r.sync;
endmodule

// ### logic/diag_monitor.sv
// Window comparator raising alarm and warning flags per value
`timescale 1ns/1ps
module diag_monitor import mgmt_pkg::*; (
   diag_if.mon dif
);
   function automatic logic beyond(input logic [15:0] v,
                                   input logic [15:0] lim,
                                   input logic        hi);
      return hi ? (v > lim) : (v < lim);
   endfunction

   always_comb begin
      for (int i = 0; i < NUM_MON; i++) begin
         for (int j = 0; j < NUM_LIM; j++) begin
            dif.flag[i][j] = beyond(dif.value[i], dif.limit[i][j],
                                    (j == LIM_HI_ALM) || (j == LIM_HI_WRN));
         end
      end
      dif.tx_fault = dif.flag[MON_BIAS][LIM_HI_ALM] |
                     dif.flag[MON_TXPWR][LIM_HI_ALM];
   end
endmodule

// ### logic/module_mgmt_twowire_slave.sv
// Two-wire management target with ID and diagnostics maps, APB side
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module module_mgmt_twowire_slave import mgmt_pkg::*; (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        scl_pin,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        tx_disable_pin,
   input  wire logic [15:0] temp_value,
   input  wire logic [15:0] bias_value,
   input  wire logic [15:0] txpwr_value,
   input  wire logic [15:0] rxpwr_value,
   input  wire logic [15:0] vcc_value,
   output logic             laser_on,
   output logic             tx_fault,
   output logic             rx_no_light_flag,
   output logic             module_missing_pin
);
   typedef struct packed {
      tw_state_t         st;
      tw_phase_t         ph;
      logic [3:0]        cnt;
      logic [7:0]        shreg;
      logic              rw;
      logic              sel;
      logic [7:0]        ptr;
      logic              drive;
      logic              acked;
      logic              scl_q;
      logic              sda_q;
      logic              mem_we;
      logic              mem_sel;
      logic [7:0]        mem_addr;
      logic [7:0]        mem_data;
      logic              from_host;
      logic [1:0]        wp;
      logic [NUM_EV-1:0] status;
      logic [NUM_EV-1:0] mask;
      logic [8:0]        memaddr;
      logic [31:0]       prdata;
      logic              laser;
      logic              fault;
      logic              los;
      logic              alarm_q;
      logic              warn_q;
   } mgmt_state_t;

   mgmt_state_t r;
   mgmt_state_t next_r;
   logic [7:0]  id_mem   [MEM_DEPTH];
   logic [7:0]  diag_mem [MEM_DEPTH];
   logic [2:0]  pins_s;
   logic        scl_s;
   logic        sda_s;
   logic        dis_s;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_c;
   logic        stop_c;
   logic        tw_edge;
   logic        byte_end;
   logic        host_wr;
   logic        los_now;
   logic        apb_wr;

   diag_if dif ();

   pin_sync #(
      .W       (3),
      .RST_VAL (PIN_IDLE)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     ({tx_disable_pin, sda_in, scl_pin}),
      .sync    (pins_s)
   );

   diag_monitor u_mon (
      .dif (dif.mon)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign dis_s = pins_s[2];

   // Edges seen on synchronised copies; host clock is far slower
   assign scl_rise = scl_s & ~r.scl_q;
   assign scl_fall = ~scl_s & r.scl_q;
   assign start_c  = scl_s & r.scl_q & r.sda_q & ~sda_s;
   assign stop_c   = scl_s & r.scl_q & ~r.sda_q & sda_s;
   assign tw_edge  = scl_fall | start_c | stop_c;
   assign byte_end = (r.st == S_RECV) && scl_fall && (r.cnt == 4'h8) &&
                     !start_c && !stop_c;

   assign dif.value = {vcc_value, rxpwr_value, txpwr_value,
                       bias_value, temp_value};
   assign los_now   = dif.flag[MON_RXPWR][LIM_LO_ALM];

   // Limits are big-endian byte pairs in the diagnostics map
   always_comb begin
      for (int i = 0; i < NUM_MON; i++) begin
         for (int j = 0; j < NUM_LIM; j++) begin
            dif.limit[i][j] = {
               diag_mem[DIAG_LIMIT_BASE + 8'(2 * (i * NUM_LIM + j))],
               diag_mem[DIAG_LIMIT_BASE + 8'(2 * (i * NUM_LIM + j) + 1)]};
         end
      end
   end

   function automatic logic [7:0] read_byte(input logic       sel,
                                            input logic [7:0] a);
      logic [7:0]  off;
      logic [19:0] fl;
      off = a - DIAG_LIVE_BASE;
      fl  = dif.flag;
      if (!sel) begin
         return id_mem[a];
      end
      if (a >= DIAG_LIVE_BASE && a < DIAG_LIVE_END) begin
         return off[0] ? dif.value[off[3:1]][7:0]
                       : dif.value[off[3:1]][15:8];
      end
      if (a == DIAG_FLAG_BASE) begin
         return fl[7:0];
      end
      if (a == DIAG_FLAG_BASE + 8'h01) begin
         return fl[15:8];
      end
      if (a == DIAG_FLAG_BASE + 8'h02) begin
         return {4'h0, fl[19:16]};
      end
      return diag_mem[a];
   endfunction

   function automatic logic writable(input logic       sel,
                                     input logic [7:0] a,
                                     input logic [1:0] wp);
      logic ro;
      ro = sel && (a >= DIAG_RO_LO) && (a <= DIAG_RO_HI);
      return !wp[sel] && !ro;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8 * b +: 8] = wd[8 * b +: 8];
         end
      end
      return res;
   endfunction

   assign host_wr = byte_end && (r.ph == PH_DATA) &&
                    writable(r.sel, r.ptr, r.wp);
   // Host bytes win the single write port; APB waits one cycle
   assign pready  = !(psel && penable && pwrite &&
                      paddr == REG_MEMDATA && host_wr);
   assign apb_wr  = psel && penable && pwrite && pready;

   always_comb begin
      logic              do_load;
      logic [7:0]        tx;
      logic [NUM_EV-1:0] ev;
      logic [NUM_EV-1:0] clr;
      logic              alarm_any;
      logic              warn_any;
      logic [31:0]       wm;
      do_load   = 1'b0;
      tx        = 8'h00;
      ev        = '0;
      clr       = '0;
      alarm_any = 1'b0;
      warn_any  = 1'b0;
      wm        = 32'h0000_0000;
      next_r    = r;
      next_r.scl_q  = scl_s;
      next_r.sda_q  = sda_s;
      next_r.mem_we = 1'b0;
      if (start_c) begin
         next_r.st    = S_RECV;
         next_r.ph    = PH_DEV;
         next_r.cnt   = 4'h0;
         next_r.drive = 1'b0;
      end else if (stop_c) begin
         next_r.st    = S_IDLE;
         next_r.drive = 1'b0;
      end else begin
         unique case (r.st)
            S_IDLE, S_IGNORE: begin
               next_r.drive = 1'b0;
            end
            S_RECV: begin
               if (scl_rise && r.cnt < 4'h8) begin
                  next_r.shreg = {r.shreg[6:0], sda_s};
                  next_r.cnt   = r.cnt + 4'h1;
               end else if (byte_end) begin
                  next_r.st    = S_ACK;
                  next_r.drive = 1'b1;
                  unique case (r.ph)
                     PH_DEV: begin
                        if (r.shreg[7:1] == ID_DEV_ADDR ||
                            r.shreg[7:1] == DIAG_DEV_ADDR) begin
                           next_r.sel = r.shreg[1];
                           next_r.rw  = r.shreg[0];
                        end else begin
                           next_r.st    = S_IGNORE;
                           next_r.drive = 1'b0;
                        end
                     end
                     PH_WADDR: begin
                        next_r.ptr = r.shreg;
                     end
                     PH_DATA: begin
                        next_r.ptr = r.ptr + 8'h01;
                     end
                  endcase
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  if (r.rw) begin
                     do_load = 1'b1;
                  end else begin
                     next_r.st    = S_RECV;
                     next_r.cnt   = 4'h0;
                     next_r.drive = 1'b0;
                     next_r.ph    = (r.ph == PH_DEV) ? PH_WADDR : PH_DATA;
                  end
               end
            end
            S_SEND: begin
               if (scl_fall) begin
                  if (r.cnt == 4'h8) begin
                     next_r.drive = 1'b0;
                     next_r.st    = S_MACK;
                  end else begin
                     next_r.shreg = {r.shreg[6:0], 1'b0};
                     next_r.drive = ~r.shreg[6];
                     next_r.cnt   = r.cnt + 4'h1;
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  next_r.acked = ~sda_s;
               end else if (scl_fall) begin
                  if (r.acked) begin
                     do_load = 1'b1;
                  end else begin
                     next_r.st = S_IGNORE;
                  end
               end
            end
         endcase
      end
      if (do_load) begin
         tx           = read_byte(r.sel, r.ptr);
         next_r.shreg = tx;
         next_r.drive = ~tx[7];
         next_r.cnt   = 4'h1;
         next_r.ptr   = r.ptr + 8'h01;
         next_r.st    = S_SEND;
      end

      if (host_wr) begin
         next_r.mem_we    = 1'b1;
         next_r.mem_sel   = r.sel;
         next_r.mem_addr  = r.ptr;
         next_r.mem_data  = r.shreg;
         next_r.from_host = 1'b1;
         ev[EV_HOST_WR]   = 1'b1;
      end else if (apb_wr && paddr == REG_MEMDATA && pstrb[0]) begin
         next_r.mem_we       = 1'b1;
         next_r.mem_sel      = r.memaddr[MEMADDR_SEL];
         next_r.mem_addr     = r.memaddr[7:0];
         next_r.mem_data     = pwdata[7:0];
         next_r.from_host    = 1'b0;
         next_r.memaddr[7:0] = r.memaddr[7:0] + 8'h01;
      end

      if (apb_wr) begin
         unique case (paddr)
            REG_CTRL: begin
               wm        = merge(32'(r.wp), pwdata, pstrb);
               next_r.wp = wm[1:0];
            end
            REG_STATUS: begin
               wm  = merge(32'h0000_0000, pwdata, pstrb);
               clr = wm[NUM_EV-1:0];
            end
            REG_MASK: begin
               wm          = merge(32'(r.mask), pwdata, pstrb);
               next_r.mask = wm[NUM_EV-1:0];
            end
            REG_MEMADDR: begin
               wm             = merge(32'(r.memaddr), pwdata, pstrb);
               next_r.memaddr = wm[8:0];
            end
            default: begin
            end
         endcase
      end

      if (psel && !penable) begin
         unique case (paddr)
            REG_CTRL:    next_r.prdata = 32'(r.wp);
            REG_STATUS:  next_r.prdata = 32'(r.status);
            REG_MASK:    next_r.prdata = 32'(r.mask);
            REG_MEMADDR: next_r.prdata = 32'(r.memaddr);
            REG_MEMDATA: next_r.prdata = 32'(read_byte(
                            r.memaddr[MEMADDR_SEL], r.memaddr[7:0]));
            REG_STATE:   next_r.prdata = 32'({r.st != S_IDLE, r.los,
                                              r.fault, r.laser});
            default:     next_r.prdata = 32'h0000_0000;
         endcase
      end

      for (int i = 0; i < NUM_MON; i++) begin
         alarm_any = alarm_any | dif.flag[i][LIM_HI_ALM] |
                     dif.flag[i][LIM_LO_ALM];
         warn_any  = warn_any | dif.flag[i][LIM_HI_WRN] |
                     dif.flag[i][LIM_LO_WRN];
      end
      ev[EV_ALARM]   = alarm_any & ~r.alarm_q;
      ev[EV_WARN]    = warn_any & ~r.warn_q;
      ev[EV_LOS]     = los_now & ~r.los;
      ev[EV_FAULT]   = dif.tx_fault & ~r.fault;
      // A fresh event outlives a clear in the same cycle
      next_r.status  = (r.status & ~clr) | ev;
      next_r.alarm_q = alarm_any;
      next_r.warn_q  = warn_any;
      next_r.laser   = ~dis_s;
      next_r.fault   = dif.tx_fault;
      next_r.los     = los_now;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r       <= '0;
         r.wp    <= CTRL_RESET;
         r.scl_q <= LINE_IDLE;
         r.sda_q <= LINE_IDLE;
      end else begin
         r <= next_r;
      end
   end

   // Cleared so thresholds and ID never read unknown before programming
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            id_mem[i]   <= 8'h00;
            diag_mem[i] <= 8'h00;
         end
      end else if (r.mem_we) begin
         if (r.mem_sel) begin
            diag_mem[r.mem_addr] <= r.mem_data;
         end else begin
            id_mem[r.mem_addr] <= r.mem_data;
         end
      end
   end

   // Open drain: data only ever pulled low, clock never driven
   assign sda_out            = 1'b0;
   assign sda_oe             = r.drive;
   assign prdata             = r.prdata;
   assign pslverr            = psel && penable && !(paddr inside {
                                  REG_CTRL, REG_STATUS, REG_MASK,
                                  REG_MEMADDR, REG_MEMDATA, REG_STATE});
   assign irq                = |(r.status & r.mask);
   assign laser_on           = r.laser;
   assign tx_fault           = r.fault;
   assign rx_no_light_flag   = r.los;
   assign module_missing_pin = 1'b0;

   localparam int OFF_BOUND = TX_OFF_CYC;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence seq_dev_byte;
      byte_end && r.ph == PH_DEV;
   endsequence

   sequence seq_dis_held;
      $rose(tx_disable_pin) ##1 tx_disable_pin [*2];
   endsequence

   a_id_addr_ack: assert property ((seq_dev_byte ##0 r.shreg[7:1] ==
      ID_DEV_ADDR) |=> sda_oe && !r.sel && r.st == S_ACK)
      else $error("ID address not acknowledged");
   a_diag_addr_ack: assert property ((seq_dev_byte ##0 r.shreg[7:1] ==
      DIAG_DEV_ADDR) |=> sda_oe && r.sel && r.st == S_ACK)
      else $error("Diagnostics address not acknowledged");
   a_foreign_quiet: assert property ((seq_dev_byte ##0
      (r.shreg[7:1] != ID_DEV_ADDR && r.shreg[7:1] != DIAG_DEV_ADDR))
      |=> r.st == S_IGNORE && !sda_oe)
      else $error("Foreign address acknowledged");
   a_ignore_released: assert property (r.st == S_IGNORE |-> !sda_oe)
      else $error("Data driven while not addressed");
   a_bit_capture: assert property ((r.st == S_RECV && scl_rise &&
      r.cnt < 4'h8 && !start_c && !stop_c) |=> r.shreg[0] == $past(sda_s)
      && r.cnt == $past(r.cnt) + 4'h1)
      else $error("Bit not captured on rising clock");
   a_wp_respected: assert property ((r.mem_we && r.from_host) |->
      !(r.mem_sel ? $past(r.wp[CTRL_DIAG_WP]) : $past(r.wp[CTRL_ID_WP])))
      else $error("Host wrote a protected memory");
   a_sda_on_fall: assert property ($changed(sda_oe) |->
      $past(tw_edge))
      else $error("Data changed away from falling clock");
   a_start_seen: assert property (start_c |=> r.st == S_RECV &&
      r.ph == PH_DEV && r.cnt == 4'h0 && !sda_oe)
      else $error("Start condition missed");
   a_stop_seen: assert property (stop_c |=> r.st == S_IDLE && !sda_oe)
      else $error("Stop condition missed");
   a_ptr_advance: assert property (host_wr |=> r.ptr ==
      $past(r.ptr) + 8'h01 && r.mem_we && r.mem_data == $past(r.shreg))
      else $error("Sequential write did not advance");
   a_live_temp: assert property ((r.st == S_ACK && scl_fall && r.rw &&
      r.sel && r.ptr == DIAG_LIVE_BASE && !start_c && !stop_c)
      |=> r.shreg == $past(dif.value[MON_TEMP][15:8]))
      else $error("Live temperature not served");
   a_alarm_flag: assert property (dif.value[MON_TEMP] >
      dif.limit[MON_TEMP][LIM_HI_ALM] |-> dif.flag[MON_TEMP][LIM_HI_ALM])
      else $error("High alarm flag missing");
   a_los_output: assert property (los_now [*2] |-> rx_no_light_flag)
      else $error("No-light output not raised");
   a_laser_off_time: assert property (seq_dis_held |->
      ##[0:OFF_BOUND] !laser_on)
      else $error("Laser not off in time");
   a_laser_held_off: assert property (tx_disable_pin [*3] |=>
      !laser_on)
      else $error("Laser on while disabled");
   a_fault_out: assert property ((dif.flag[MON_BIAS][LIM_HI_ALM] ||
      dif.flag[MON_TXPWR][LIM_HI_ALM]) [*2] |-> tx_fault)
      else $error("Fault output not raised");
   a_presence_low: assert property (module_missing_pin == 1'b0)
      else $error("Presence output not low");
endmodule

// ### tb/host_master.sv
// Two-wire bus master standing in for the host board controller
`timescale 1ns/1ps
module host_master (
   output logic      scl,
   output logic      oe,
   input  wire logic sda
);
   // Quarter of the 200 ns link clock period
   localparam time Q = 50ns;
   initial begin
      scl = 1'b1;
      oe = 1'b0;
   end
   // Host alone makes the clock; data moves only while it is low
   task automatic bit_io(input logic b, output logic r);
      #Q oe = !b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
   endtask
   // Data moves while clock is high: start and stop
   task automatic start();
      #Q oe = 1'b0;
      #Q scl = 1'b1;
      #Q oe = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic stop();
      #Q oe = 1'b1;
      #Q scl = 1'b1;
      #Q oe = 1'b0;
      #Q;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // Last byte of a read is refused so the target lets go
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule

// ### tb/module_mgmt_twowire_slave_test.sv
// Self-checking bench for the two-wire management target
`timescale 1ns/1ps
module module_mgmt_twowire_slave_test import mgmt_pkg::*;;
   logic        ref_clk, rst, psel, penable, pwrite, tdis, host_oe, scl;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] temp, bias, rxp;
   logic        pready, pslverr, irq, sda_out, sda_oe, ack, err;
   logic        laser_on, tx_fault, no_light, missing;
   logic [7:0]  d;
   wire         sda = host_oe ? 1'b0 : (sda_oe ? sda_out : 1'b1);
   int          n_fail = 0, checks = 0, cyc = 0;
   module_mgmt_twowire_slave DUT (.ref_clk(ref_clk), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .scl_pin(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .tx_disable_pin(tdis),
      .temp_value(temp), .bias_value(bias), .txpwr_value(16'h0000),
      .rxpwr_value(rxp), .vcc_value(16'h0000), .laser_on(laser_on),
      .tx_fault(tx_fault), .rx_no_light_flag(no_light),
      .module_missing_pin(missing));
   host_master h (.scl(scl), .oe(host_oe), .sda(sda));
   task automatic chk(input string n, input logic [31:0] e, s);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] wd);
      @(posedge ref_clk);
      {paddr, pwrite, pwdata, psel, penable} <= {a, w, wd, 2'b10};
      @(posedge ref_clk);
      penable <= 1'b1;
      // Looked at mid-cycle: pready and prdata hold until the next edge
      do @(negedge ref_clk); while (pready !== 1'b1);
      q   = prdata;
      err = pslverr;
      @(posedge ref_clk);
      {psel, penable} <= 2'b00;
   endtask
   // Ends off the edge so the next host frame never races the sampler
   task automatic mem_rd(input logic [8:0] a);
      apb(REG_MEMADDR, 1'b1, {23'h0, a});
      apb(REG_MEMDATA, 1'b0, 32'h0);
      @(negedge ref_clk);
   endtask
   task automatic t_laser();
      tdis <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk("laser", 1, laser_on);
      tdis <= 1'b1;
      repeat (TX_OFF_CYC) @(posedge ref_clk);
      chk("laser", 0, laser_on);
      chk("missing", 0, missing);
   endtask
   task automatic t_twowire();
      @(negedge ref_clk);
      h.start();
      h.send(8'hA2, ack);
      chk("ack", 1, ack);
      h.send(8'h00, ack);
      h.send(8'h12, ack);
      h.send(8'h34, ack);
      h.stop();
      mem_rd(9'h101);
      chk("diag", 32'h34, q);
      h.start();
      h.send(8'hA0, ack);
      h.send(8'h05, ack);
      h.send(8'h5A, ack);
      h.stop();
      chk("ack", 1, ack);
      mem_rd(9'h005);
      chk("id", 32'h0, q);
      h.start();
      h.send(8'hA2, ack);
      h.send(8'h60, ack);
      h.start();
      h.send(8'hA3, ack);
      h.recv(1'b0, d);
      chk("live", 8'hBE, d);
      h.recv(1'b1, d);
      h.stop();
      chk("live", 8'hEF, d);
      h.start();
      h.send(8'hA4, ack);
      h.stop();
      chk("ack", 0, ack);
   endtask
   task automatic t_events();
      apb(REG_MASK, 1'b1, 32'h10);
      @(negedge ref_clk);
      chk("irq", 1, irq);
      apb(REG_STATUS, 1'b1, 32'h10);
      @(negedge ref_clk);
      chk("irq", 0, irq);
      apb(12'h020, 1'b0, 32'h0);
      chk("slverr", 1, err);
      apb(REG_MEMADDR, 1'b1, 32'h11B);
      apb(REG_MEMDATA, 1'b1, 32'h20);
      bias <= 16'h0005;
      repeat (8) @(posedge ref_clk);
      chk("no_light", 1, no_light);
      chk("fault", 1, tx_fault);
      apb(REG_STATE, 1'b0, 32'h0);
      chk("state", 32'h6, q);
   endtask
   task automatic end_of_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      {rst, psel, penable, pwrite, tdis} = 5'b10001;
      {paddr, pwdata, temp, bias, rxp} = {12'h0, 32'h0, 48'hBEEF00000010};
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      t_laser();
      t_twowire();
      t_events();
      end_of_test();
   end
endmodule
